// ---- rtl/vps_supervisor.sv ----
/*
 Bus power path supervisor: checks the bus comparator results against the configured window or UVLO and the supply ones
 against their limits, drives the active-low source power path
 enable as an open-drain pin, sequences internal and external discharge and
 runs the fault recovery entry and exit.
 Assumes all inputs are synchronous to clk_sys and that the analog window
 comparators take their thresholds from the percent outputs of this block.
*/
`timescale 1ns/1ps
module vps_supervisor
   import vps_pkg::*;
#(
   parameter int unsigned WIN_STEP = WIN_STEP_CYC,
   parameter int unsigned ZERO_STEP = ZERO_STEP_CYC,
   parameter int unsigned RECOVER = RECOVER_CYC
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Attach state machine.
   input wire vps_attach_t attach_state,
   input wire logic profile_change,
   input wire logic profile_lower,
   // Comparator results.
   input wire vps_monitor_t mon,
   // NVM straps and software configuration.
   input wire vps_config_t nvm_cfg,
   input wire logic nvm_discharge_enable,
   input wire logic nvm_discharge_active_high,
   input wire logic sw_write,
   input wire vps_config_t sw_cfg,
   // Window targets for the comparators, in percent of nominal.
   output logic [4:0] window_high_pct,
   output logic [4:0] window_low_pct,
   output logic monitor_armed,
   // Power path enable open-drain pin.
   output logic source_power_path_enable_n_o,
   output logic source_power_path_enable_n_oe,
   // Discharge.
   output logic internal_discharge,
   output logic external_discharge_control,
   // Fault recovery requests to the attach state machine.
   output logic fault_recovery_state,
   output logic cc_termination_off,
   output logic recovery_done,
   // Software-visible flags.
   output vps_flags_t flags
);

   // Current configuration.
   vps_config_t cfg;
   // Sequencer state.
   vps_state_t state_reg;
   vps_state_t state_next;
   // Change window and zero discharge timers.
   logic win_busy;
   logic zero_busy;
   logic win_start;
   logic zero_start;
   // Recovery interval counter.
   logic [31:0] rec_cnt_reg;
   // Discharge mode captured with the current window.
   logic step_down_reg;
   // Latched NVM discharge straps.
   logic dis_en_reg;
   logic dis_pol_reg;
   // Previous attached-state indication for edge detection.
   logic src_prev_reg;
   // Power path has been asserted since attach.
   logic enabled_reg;
   // Combinational conditions.
   logic in_source;
   logic bus_ok;
   logic supply_ok;
   logic hw_fault;
   logic attach_edge;
   logic detach_edge;
   logic window_fault;
   logic supply_fault;
   logic enable_now;
   // Discharge wanted, seen in the same cycle as its cause.
   logic discharge_now;

   ///////////////////////////////////////////////////////////////////////////
   // Helpers.

   // True for the three states in which the power path may be enabled.
   function automatic logic source_state(input vps_attach_t a);
      source_state = (a == ATT_SOURCE) || (a == ATT_DEBUG_UNORIENTED) ||
                     (a == ATT_DEBUG_ORIENTED);
   endfunction : source_state

   // Window limit in percent: fixed base plus the configured outward shift.
   function automatic logic [4:0] limit_pct(input logic [3:0] shift);
      limit_pct = SHIFT_BASE_PCT + {1'b0, shift};
   endfunction : limit_pct

   ///////////////////////////////////////////////////////////////////////////
   // Submodules.

   // Configuration with NVM defaults and software overwrite.
   vps_cfg u_cfg (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .nvm_cfg(nvm_cfg),
      .sw_write(sw_write),
      .sw_cfg(sw_cfg),
      .attached(in_source),
      .cfg(cfg)
   );

   // Profile change window timer in 20 ms steps.
   vps_timer #(.STEP_CYC(WIN_STEP)) u_win (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(win_start),
      .steps(cfg.window_code),
      .busy(win_busy)
   );

   // Discharge to zero timer in 84 ms steps.
   vps_timer #(.STEP_CYC(ZERO_STEP)) u_zero (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(zero_start),
      .steps(cfg.zero_code),
      .busy(zero_busy)
   );

   ///////////////////////////////////////////////////////////////////////////
   // Condition decode.

   always_comb begin
      in_source = source_state(attach_state);
      attach_edge = in_source && !src_prev_reg;
      detach_edge = !in_source && src_prev_reg && (state_reg == SUP_ATTACHED);
      // Bus condition per selection.
      bus_ok = cfg.bus_window_check_select ?
               (!mon.bus_above_high && !mon.bus_below_low) :
               mon.bus_above_uvlo;
      // Enabled supply checks only.
      supply_ok = (!cfg.supply_undervoltage_check || mon.supply_above_uvlo) &&
                  (!cfg.supply_overvoltage_check || mon.supply_below_ovlo);
      hw_fault = mon.overtemp || mon.pullup_low || mon.cc_overvoltage;
      // Window loss is checked only outside the change window.
      window_fault = (state_reg == SUP_ATTACHED) && !win_busy && !bus_ok;
      // Supply checks guard until the enable is first given.
      supply_fault = (state_reg == SUP_ATTACHED) && !enabled_reg && !win_busy &&
                     !supply_ok;
      // Enable needs attach, bus condition met even during the monitoring mute, no device fault and the enabled supply checks until first given.
      enable_now = (state_reg == SUP_ATTACHED) && in_source && bus_ok &&
                   (enabled_reg || supply_ok) && !hw_fault && !window_fault;
      // Timer starts: attach or profile change retarget the window.
      win_start = (attach_edge && state_reg == SUP_IDLE) ||
                  (profile_change && state_reg == SUP_ATTACHED);
      zero_start = detach_edge ||
                   (state_next == SUP_RECOVERY && state_reg != SUP_RECOVERY);
      // Discharge from the cycle a detach, recovery or step-down is seen.
      discharge_now = dis_en_reg && (zero_start || zero_busy ||
                      (win_busy && step_down_reg) ||
                      (win_start && profile_change && profile_lower));
   end

   ///////////////////////////////////////////////////////////////////////////
   // Sequencer next state.

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SUP_IDLE: begin
            // A device fault wins over attachment; attach enters attached whatever the bus level.
            if (hw_fault) begin
               state_next = SUP_RECOVERY;
            end else if (attach_edge) begin
               state_next = SUP_ATTACHED;
            end
         end
         SUP_ATTACHED: begin
            if (hw_fault || window_fault || supply_fault) begin
               state_next = SUP_RECOVERY;
            end else if (!in_source) begin
               state_next = SUP_IDLE;
            end
         end
         SUP_RECOVERY: begin
            // Leave after the fixed termination removal interval.
            if (rec_cnt_reg == RECOVER - 1) begin
               state_next = SUP_IDLE;
            end
         end
         default: begin
            state_next = SUP_IDLE;
         end
      endcase
   end

   ///////////////////////////////////////////////////////////////////////////
   // Sequencer state register.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= SUP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Recovery interval counter on the core clock.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rec_cnt_reg <= 32'h0;
      end else if (state_reg == SUP_RECOVERY) begin
         rec_cnt_reg <= rec_cnt_reg + 32'h1;
      end else begin
         rec_cnt_reg <= 32'h0;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Edge tracking, enable history and step direction.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         src_prev_reg <= 1'b0;
         enabled_reg <= 1'b0;
         step_down_reg <= 1'b0;
      end else begin
         src_prev_reg <= in_source;
         // Remember that the path was enabled; cleared when leaving attach.
         if (state_next != SUP_ATTACHED) begin
            enabled_reg <= 1'b0;
         end else if (enable_now) begin
            enabled_reg <= 1'b1;
         end
         // A step down keeps discharge on for the new window.
         if (win_start) begin
            step_down_reg <= profile_change && profile_lower;
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // NVM discharge straps caught while idle and detached; no software write path.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dis_en_reg <= 1'b1;
         dis_pol_reg <= 1'b0;
      end else if (state_reg == SUP_IDLE && !src_prev_reg && !in_source) begin
         dis_en_reg <= nvm_discharge_enable;
         dis_pol_reg <= nvm_discharge_active_high;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Window targets for the comparators.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         window_high_pct <= SHIFT_BASE_PCT + {1'b0, SHIFT_HIGH_DEFAULT};
         window_low_pct <= SHIFT_BASE_PCT + {1'b0, SHIFT_LOW_DEFAULT};
         monitor_armed <= 1'b0;
      end else begin
         window_high_pct <= limit_pct(cfg.shift_high);
         window_low_pct <= limit_pct(cfg.shift_low);
         // A retarget in this cycle mutes monitoring at once, not one cycle late.
         monitor_armed <= (state_reg == SUP_ATTACHED) && in_source && !win_busy &&
                          !win_start;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Power path enable pin: drives low only when enabled, else released.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         source_power_path_enable_n_o <= 1'b1;
         source_power_path_enable_n_oe <= 1'b0;
      end else begin
         source_power_path_enable_n_o <= 1'b0;
         source_power_path_enable_n_oe <= enable_now && (state_next == SUP_ATTACHED);
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Discharge outputs: detach, recovery, and a step-down window.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         internal_discharge <= 1'b0;
         external_discharge_control <= 1'b1;
      end else begin
         internal_discharge <= discharge_now;
         external_discharge_control <= dis_pol_reg ~^ discharge_now;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Recovery outputs to the attach state machine.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fault_recovery_state <= 1'b0;
         cc_termination_off <= 1'b0;
         recovery_done <= 1'b0;
      end else begin
         fault_recovery_state <= (state_next == SUP_RECOVERY);
         cc_termination_off <= (state_next == SUP_RECOVERY);
         recovery_done <= (state_reg == SUP_RECOVERY) && (state_next == SUP_IDLE);
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Flags: live faults, gated by the check setting for the supply checks.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         // The released pin reads high through its pull-up.
         flags <= '{power_path_status: 1'b1, default: 1'b0};
      end else begin
         flags.overtemperature_flag <= mon.overtemp;
         flags.pullup_supply_low_flag <= mon.pullup_low;
         flags.cc_overvoltage_flag <= mon.cc_overvoltage;
         flags.bus_window_fault_flag <= window_fault;
         flags.supply_low_fault_flag <= cfg.supply_undervoltage_check &&
                                        !mon.supply_above_uvlo;
         flags.supply_high_fault_flag <= cfg.supply_overvoltage_check &&
                                         !mon.supply_below_ovlo;
         flags.power_path_status <= !(enable_now && (state_next == SUP_ATTACHED));
      end
   end

endmodule : vps_supervisor

// ---- rtl/vps_pkg.sv ----
/*
 Package for the bus power path supervisor: timing figures, window shift
 limits, attach states and the grouped comparator and configuration carriers.
 Assumes a single 50 MHz core clock and that the package is compiled first.
*/
package vps_pkg;

   // Core clock rate in kHz, used to turn milliseconds into cycles.
   localparam int unsigned CLK_KHZ = 50000;

   // Profile change window step and default, in ms.
   localparam int unsigned WIN_STEP_MS = 20;
   localparam int unsigned WIN_DEFAULT_MS = 280;
   localparam logic [3:0] WIN_CODE_DEFAULT = 4'(WIN_DEFAULT_MS / WIN_STEP_MS);

   // Discharge to zero step and default, in ms.
   localparam int unsigned ZERO_STEP_MS = 84;
   localparam int unsigned ZERO_DEFAULT_MS = 168;
   localparam logic [3:0] ZERO_CODE_DEFAULT = 4'(ZERO_DEFAULT_MS / ZERO_STEP_MS);

   // Termination removal interval during fault recovery, in ms.
   localparam int unsigned RECOVER_MS = 30;

   // Cycle counts per step, derived from the rate.
   localparam int unsigned WIN_STEP_CYC = WIN_STEP_MS * CLK_KHZ;
   localparam int unsigned ZERO_STEP_CYC = ZERO_STEP_MS * CLK_KHZ;
   localparam int unsigned RECOVER_CYC = RECOVER_MS * CLK_KHZ;

   // Window limits in percent: fixed base plus shift of one to fifteen.
   localparam logic [4:0] SHIFT_BASE_PCT = 5'h05;
   localparam logic [3:0] SHIFT_MIN = 4'h1;
   localparam logic [3:0] SHIFT_MAX = 4'hF;
   localparam logic [3:0] SHIFT_HIGH_DEFAULT = 4'h5;
   localparam logic [3:0] SHIFT_LOW_DEFAULT = 4'h5;

   // Attach state reported by the attach state machine.
   typedef enum logic [2:0] {
      ATT_UNATTACHED = 3'b000,
      ATT_ATTACH_WAIT = 3'b001,
      ATT_SOURCE = 3'b010,
      ATT_DEBUG_UNORIENTED = 3'b011,
      ATT_DEBUG_ORIENTED = 3'b100
   } vps_attach_t;

   // Supervisor sequencer states.
   typedef enum logic [1:0] {
      SUP_IDLE = 2'b00,
      SUP_ATTACHED = 2'b01,
      SUP_RECOVERY = 2'b10
   } vps_state_t;

   // Comparator results, all active high.
   typedef struct packed {
      logic bus_above_high;
      logic bus_below_low;
      logic bus_above_uvlo;
      logic supply_above_uvlo;
      logic supply_below_ovlo;
      logic overtemp;
      logic pullup_low;
      logic cc_overvoltage;
   } vps_monitor_t;

   // Run-time configuration (NVM default, overwritable by software).
   typedef struct packed {
      logic [3:0] shift_high;
      logic [3:0] shift_low;
      logic [3:0] window_code;
      logic [3:0] zero_code;
      logic supply_undervoltage_check;
      logic supply_overvoltage_check;
      logic bus_window_check_select;
   } vps_config_t;

   // Fault and status flags seen by software.
   typedef struct packed {
      logic overtemperature_flag;
      logic pullup_supply_low_flag;
      logic cc_overvoltage_flag;
      logic bus_window_fault_flag;
      logic supply_low_fault_flag;
      logic supply_high_fault_flag;
      logic power_path_status;
   } vps_flags_t;

endpackage : vps_pkg

// ---- rtl/vps_timer.sv ----
/*
 Step timer: counts a programmable number of fixed length steps.
 Assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
module vps_timer
   import vps_pkg::*;
#(
   parameter int unsigned STEP_CYC = 1000
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Control.
   input wire logic start,
   input wire logic [3:0] steps,
   // Status.
   output logic busy
);

   // Cycle counter within one step.
   logic [31:0] cyc_reg;
   // Steps still to run.
   logic [3:0] left_reg;

   ///////////////////////////////////////////////////////////////////////////
   // Count cycles and steps; a zero step count ends at once.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cyc_reg <= 32'h0;
         left_reg <= 4'h0;
         busy <= 1'b0;
      end else if (start) begin
         cyc_reg <= 32'h0;
         left_reg <= steps;
         busy <= (steps != 4'h0);
      end else if (busy) begin
         if (cyc_reg == STEP_CYC - 1) begin
            cyc_reg <= 32'h0;
            left_reg <= left_reg - 4'h1;
            // Last step done.
            if (left_reg == 4'h1) begin
               busy <= 1'b0;
            end
         end else begin
            cyc_reg <= cyc_reg + 32'h1;
         end
      end
   end

endmodule : vps_timer

// ---- rtl/vps_cfg.sv ----
/*
 Configuration holder: loads NVM defaults while reset is low and accepts
 software writes while attached. Shift values are clamped to their legal span.
 Assumes nvm_cfg is stable and valid whenever reset is low.
*/
`timescale 1ns/1ps
module vps_cfg
   import vps_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Sources.
   input wire vps_config_t nvm_cfg,
   input wire logic sw_write,
   input wire vps_config_t sw_cfg,
   input wire logic attached,
   // Result.
   output vps_config_t cfg
);

   // Keep a shift setting inside one to fifteen percent.
   function automatic logic [3:0] clamp_shift(input logic [3:0] s);
      clamp_shift = (s < SHIFT_MIN) ? SHIFT_MIN : s;
   endfunction : clamp_shift

   // Pass a configuration through the clamps.
   function automatic vps_config_t legal(input vps_config_t c);
      vps_config_t r;
      r = c;
      r.shift_high = clamp_shift(c.shift_high);
      r.shift_low = clamp_shift(c.shift_low);
      legal = r;
   endfunction : legal

   ///////////////////////////////////////////////////////////////////////////
   // Reset copies NVM defaults; software may overwrite while attached.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg <= legal(nvm_cfg);
      end else if (sw_write && attached) begin
         cfg <= legal(sw_cfg);
      end
   end

endmodule : vps_cfg

// ---- dv/vps_assertions.sv ----
/*
 Checker for the bus power path supervisor, bound to its top module.
 Assumes one clock domain and the shortened recovery count of the bench.
*/
`timescale 1ns/1ps
module vps_assertions
   import vps_pkg::*;
#(
   parameter int unsigned WIN_STEP = 10,
   parameter int unsigned ZERO_STEP = 10,
   parameter int unsigned RECOVER = 20
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Watched inputs.
   input wire vps_attach_t attach_state,
   input wire logic profile_change,
   input wire logic profile_lower,
   input wire vps_monitor_t mon,
   input wire vps_config_t nvm_cfg,
   input wire logic nvm_discharge_enable,
   input wire logic nvm_discharge_active_high,
   // Watched outputs.
   input wire logic [4:0] window_high_pct,
   input wire logic [4:0] window_low_pct,
   input wire logic monitor_armed,
   input wire logic source_power_path_enable_n_o,
   input wire logic source_power_path_enable_n_oe,
   input wire logic internal_discharge,
   input wire logic external_discharge_control,
   input wire logic fault_recovery_state,
   input wire logic cc_termination_off,
   input wire logic recovery_done,
   input wire vps_flags_t flags
);
   // Recovery exit may land one cycle either side of the nominal count.
   localparam int REC_LO = RECOVER - 1;
   localparam int REC_HI = RECOVER + 1;
   // High while the attach machine reports a sourcing state.
   logic in_src;
   assign in_src = attach_state inside {ATT_SOURCE, ATT_DEBUG_UNORIENTED, ATT_DEBUG_ORIENTED};
   // Any device fault that forces recovery.
   logic hw_fault;
   assign hw_fault = mon.overtemp | mon.pullup_low | mon.cc_overvoltage;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Start of a recovery episode.
   sequence rec_entry;
      $rose(fault_recovery_state);
   endsequence
   en_src_state_a: assert property (source_power_path_enable_n_oe |-> $past(in_src))
      else $error("enable driven outside source states");
   en_drive_low_a: assert property (source_power_path_enable_n_oe |->
      !source_power_path_enable_n_o)
      else $error("enable pin driven high");
   status_mirror_a: assert property (flags.power_path_status ==
      !source_power_path_enable_n_oe)
      else $error("status bit differs from pin");
   rec_release_a: assert property (rec_entry |->
      (!source_power_path_enable_n_oe && cc_termination_off)[*8])
      else $error("recovery kept enable or terminations");
   rec_disch_a: assert property (rec_entry ##0 nvm_discharge_enable |->
      internal_discharge)
      else $error("no discharge in recovery");
   rec_length_a: assert property (rec_entry |-> ##[REC_LO:REC_HI] recovery_done)
      else $error("recovery length wrong");
   hw_fault_a: assert property ($rose(hw_fault) |=> fault_recovery_state)
      else $error("device fault did not start recovery");
   win_loss_a: assert property (monitor_armed && nvm_cfg.bus_window_check_select &&
      (mon.bus_above_high || mon.bus_below_low) |=> fault_recovery_state)
      else $error("window loss did not start recovery");
   chg_mute_a: assert property (profile_change && in_src |=> !monitor_armed)
      else $error("monitoring live in change window");
   lower_disch_a: assert property (profile_change && profile_lower && nvm_discharge_enable
      |=> internal_discharge[*8])
      else $error("no discharge on downward change");
   pct_span_a: assert property (window_high_pct inside {[5'h06:5'h14]} &&
      window_low_pct inside {[5'h06:5'h14]})
      else $error("window limit out of span");
   ext_pol_a: assert property ($rose(internal_discharge) && !nvm_discharge_active_high |->
      !external_discharge_control)
      else $error("external discharge polarity wrong");
endmodule : vps_assertions
bind vps_supervisor vps_assertions #(.WIN_STEP(WIN_STEP), .ZERO_STEP(ZERO_STEP),
   .RECOVER(RECOVER)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .attach_state(attach_state), .profile_change(profile_change),
   .profile_lower(profile_lower), .mon(mon), .nvm_cfg(nvm_cfg), .flags(flags),
   .nvm_discharge_enable(nvm_discharge_enable), .nvm_discharge_active_high(nvm_discharge_active_high),
   .window_high_pct(window_high_pct), .window_low_pct(window_low_pct), .monitor_armed(monitor_armed),
   .source_power_path_enable_n_o(source_power_path_enable_n_o),
   .source_power_path_enable_n_oe(source_power_path_enable_n_oe),
   .internal_discharge(internal_discharge), .external_discharge_control(external_discharge_control),
   .fault_recovery_state(fault_recovery_state), .cc_termination_off(cc_termination_off),
   .recovery_done(recovery_done));

// ---- dv/vps_far_side.sv ----
/*
 Far side model: pulled-up enable pin and bus comparators.
 Assumes the bench commands a bus overvoltage through bus_bad.
*/
`timescale 1ns/1ps
module vps_far_side (
   // Enable pin halves from the supervisor.
   input wire logic en_n_o,
   input wire logic en_n_oe,
   // Fault command from the bench.
   input wire logic bus_bad,
   // Resolved pin and bus comparator levels.
   output logic pin_level,
   output logic above_high,
   output logic below_low,
   output logic above_uvlo
);
   // The external pull-up holds the pin high whenever it is released.
   assign pin_level = en_n_oe ? en_n_o : 1'b1;
   // An overvoltage sits above the window but well above undervoltage too.
   assign above_high = bus_bad;
   assign below_low = 1'b0;
   assign above_uvlo = 1'b1;
endmodule : vps_far_side

// ---- dv/testbench.sv ----
/*
 Self-checking bench for the supervisor with shortened timers.
 Assumes the far side model and the bound checker are compiled beforehand.
*/
`timescale 1ns/1ps
module testbench;
   import vps_pkg::*;
   localparam int unsigned RC = 20;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   vps_attach_t att = ATT_UNATTACHED;
   logic chg = 1'b0, low = 1'b0, bad = 1'b0, sup = 1'b1, swr = 1'b0, den = 1'b1, pol = 1'b0;
   logic [2:0] hw = 3'h0;
   vps_config_t nvm = '{4'h5, 4'h5, WIN_CODE_DEFAULT, ZERO_CODE_DEFAULT, 1'b1, 1'b0, 1'b1};
   vps_config_t sw = '{4'h5, 4'h5, WIN_CODE_DEFAULT, ZERO_CODE_DEFAULT, 1'b1, 1'b0, 1'b1};
   logic hi, lo, uv, pin, o, oe, armed, idis, edis, frs, cto, done;
   logic [4:0] wh, wl;
   vps_flags_t fl;
   vps_monitor_t mon;
   int miscompares = 0;
   int checked = 0;
   int n;
   // Supply above overvoltage check is never exercised.
   assign mon = vps_monitor_t'({hi, lo, uv, sup, 1'b1, hw});
   vps_supervisor #(.WIN_STEP(10), .ZERO_STEP(10), .RECOVER(RC)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .attach_state(att), .profile_change(chg), .profile_lower(low), .mon(mon),
      .nvm_cfg(nvm), .nvm_discharge_enable(den), .nvm_discharge_active_high(pol),
      .sw_write(swr), .sw_cfg(sw), .window_high_pct(wh), .window_low_pct(wl),
      .monitor_armed(armed), .source_power_path_enable_n_o(o),
      .source_power_path_enable_n_oe(oe), .internal_discharge(idis),
      .external_discharge_control(edis), .fault_recovery_state(frs), .cc_termination_off(cto),
      .recovery_done(done), .flags(fl));
   vps_far_side far (.en_n_o(o), .en_n_oe(oe), .bus_bad(bad), .pin_level(pin),
      .above_high(hi), .below_low(lo), .above_uvlo(uv));
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task chk(input logic [4:0] got, input logic [4:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : cyc
   // Ends the run when a bounded wait used up its limit.
   task bound;
      if (n >= 300) begin
         miscompares++;
         $display("wrong value at %0t: wait ran out", $time);
         conclude();
      end
   endtask : bound
   // Detaches, lets any recovery finish, then enters the given state.
   task go(input vps_attach_t s);
      att = ATT_UNATTACHED;
      for (n = 0; n < 300 && frs !== 1'b0; n++) cyc(1);
      bound();
      cyc(2);
      att = s;
      cyc(2);
   endtask : go
   task t_attach;
      chk(wh, 5'h0A);
      chk(edis, 1'b1);
      for (int i = 2; i < 5; i++) begin
         go(vps_attach_t'(i));
         chk(pin, 1'b0);
         chk(fl.power_path_status, 1'b0);
      end
      go(ATT_ATTACH_WAIT);
      cyc(3);
      chk(pin, 1'b1);
      bad = 1'b1;
      go(ATT_SOURCE);
      cyc(5);
      chk(oe, 1'b0);
      bad = 1'b0;
   endtask : t_attach
   task t_profile;
      go(ATT_SOURCE);
      for (n = 0; n < 300 && armed !== 1'b1; n++) cyc(1);
      bound();
      {chg, low} = 2'b11;
      cyc(1);
      {chg, low, bad} = 3'b001;
      chk(armed, 1'b0);
      for (n = 0; n < 300 && armed !== 1'b1; n++) begin
         chk({idis, frs}, 2'b10);
         cyc(1);
      end
      bound();
      chk(n == WIN_CODE_DEFAULT * 10 + 1, 1'b1);
      chk({frs, oe, cto, idis}, 4'hB);
      chk(fl.bus_window_fault_flag, 1'b1);
      bad = 1'b0;
      for (n = 0; n < 300 && done !== 1'b1; n++) cyc(1);
      chk(n >= RC - 3 && n <= RC + 1, 1'b1);
   endtask : t_profile
   task t_faults;
      for (int i = 0; i < 3; i++) begin
         go(ATT_UNATTACHED);
         hw = 3'h1 << i;
         cyc(1);
         chk(frs, 1'b1);
         chk({fl.overtemperature_flag, fl.pullup_supply_low_flag, fl.cc_overvoltage_flag}, hw);
         hw = 3'h0;
      end
   endtask : t_faults
   task t_supply;
      sup = 1'b0;
      go(ATT_SOURCE);
      cyc(10);
      chk(oe, 1'b0);
      chk(fl.supply_low_fault_flag, 1'b1);
      sup = 1'b1;
      go(ATT_SOURCE);
      chk(oe, 1'b1);
      sup = 1'b0;
      cyc(10);
      chk({oe, frs}, 2'b10);
      sup = 1'b1;
      att = ATT_UNATTACHED;
      cyc(1);
      chk({oe, idis, edis}, 3'b010);
   endtask : t_supply
   task t_shift;
      go(ATT_SOURCE);
      sw.shift_high = 4'h0;
      sw.shift_low = 4'hF;
      swr = 1'b1;
      cyc(1);
      swr = 1'b0;
      cyc(2);
      chk(wh, 5'h06);
      chk(wl, 5'h14);
      att = ATT_UNATTACHED;
      sw.shift_high = 4'hF;
      cyc(1);
      swr = 1'b1;
      cyc(1);
      swr = 1'b0;
      cyc(2);
      chk(wh, 5'h06);
   endtask : t_shift
   // Straps taken while detached: discharge off, external control active high.
   task t_strap;
      {den, pol} = 2'b01;
      go(ATT_SOURCE);
      att = ATT_UNATTACHED;
      cyc(1);
      chk({idis, edis}, 2'b00);
   endtask : t_strap
   initial begin
      cyc(16);
      rst_n = 1'b1;
      t_attach();
      t_profile();
      t_faults();
      t_supply();
      t_shift();
      t_strap();
      conclude();
   end
endmodule : testbench
